// ---- dv/test_usb_source_detect_input_limit.sv ----
`timescale 1ns/10ps

module test_usb_source_detect_input_limit;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic rd_seen = 1'b0;
    logic vbus = 1'b0;
    logic pg = 1'b0;
    logic above = 1'b0;
    logic msreg = 1'b0;
    logic wdog = 1'b0;
    logic [2:0] pin = 3'h7;
    logic [2:0] mode = 3'h0;
    logic [2:0] m;
    logic [12:0] delay = 13'h0BB8;
    logic [7:0] rdata;
    logic dp_src, dm_pd, dp_vsrc, dm_sink, conv, bsw, high_impedance_standby, pg_ev, dp_high, dm_high;
    logic [2:0] lim, minsel, div;
    logic [7:0] exp_q[$];
    logic [1:0] src_t [6] = '{2'h1, 2'h2, 2'h0, 2'h2, 2'h2, 2'h2};
    logic [2:0] lim_t [6] = '{3'h2, 3'h7, 3'h2, 3'h6, 3'h6, 3'h4};
    int err_total = 0;
    int total_checks = 0;
    int cycles = 0;
    int seed = 44593;
    int n;

    always #5 clk_i = ~clk_i;

    // Short ms tick keeps the 0.5 s contact timeout at 5000 cycles
    usb_source_detect #(.TICK_CYCLES(10)) dut (
        .clk_i(clk_i), .rst_i(rst_i), .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
        .rdata_o(rdata), .vbus_present_i(vbus), .power_good_i(pg), .dp_high_i(dp_high),
        .dm_high_i(dm_high), .divider1_i(div[0]), .divider2_i(div[1]), .divider3_i(div[2]),
        .sys_above_min_i(above), .min_sys_regulating_i(msreg), .external_limit_pin_i(pin),
        .watchdog_timeout_i(wdog), .dp_current_source_o(dp_src), .dm_pulldown_o(dm_pd),
        .dp_voltage_source_o(dp_vsrc), .dm_current_sink_o(dm_sink), .input_limit_o(lim),
        .converter_enable_o(conv), .battery_switch_o(bsw), .high_impedance_standby_o(high_impedance_standby),
        .min_sys_select_o(minsel), .power_good_event_o(pg_ev));

    usb_port_model partner (
        .clk_i(clk_i), .rst_i(rst_i), .mode_i(mode), .delay_i(delay), .dp_src_i(dp_src),
        .dp_vsrc_i(dp_vsrc), .dm_sink_i(dm_sink), .dp_high_o(dp_high), .dm_high_o(dm_high),
        .div_o(div));

    // ----------------------------------------
    // Checking and report
    // ----------------------------------------
    task stop_test;
        $display("Checks %0d, errors %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : stop_test

    task chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk

    always @(posedge clk_i) begin
        rd_seen <= rd;
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            err_total++;
            $display("[FAIL] %0t run did not finish", $time);
            stop_test();
        end
    end

    always @(negedge clk_i) begin
        if (rd_seen) begin
            chk(rdata, exp_q.pop_front(), "read data");
        end
    end

    // ----------------------------------------
    // Bus and sequence helpers
    // ----------------------------------------
    function automatic logic [2:0] exp_lim(input logic [2:0] r);
        return above ? ((r < pin) ? r : pin) : 3'h0;
    endfunction : exp_lim

    function automatic logic [7:0] stat(input logic [1:0] s);
        return {s, 3'h0, 1'b1, 1'b0, msreg};
    endfunction : stat

    task wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk_i);
        wr <= 1'b0;
    endtask : wr_reg

    task rd_reg(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk_i);
        addr <= a;
        rd <= 1'b1;
        exp_q.push_back(e);
        @(posedge clk_i);
        rd <= 1'b0;
        @(negedge clk_i);
    endtask : rd_reg

    task wait_conv(input logic lvl);
        for (n = 0; n < 8000 && conv !== lvl; n++) @(negedge clk_i);
        chk({7'h00, conv}, {7'h00, lvl}, "converter enable");
    endtask : wait_conv

    task detect(input logic [2:0] md, input logic [1:0] s, input logic [2:0] l, input logic by_wd);
        @(posedge clk_i);
        mode <= md;
        pin <= 3'($random(seed));
        if (by_wd) begin
            wdog <= 1'b1;
            @(posedge clk_i);
            wdog <= 1'b0;
        end else begin
            wr_reg(8'h07, 8'h80);
        end
        wait_conv(1'b0);
        chk({5'h00, lim}, 8'h00, "forced limit");
        wait_conv(1'b1);
        @(negedge clk_i);
        chk({5'h00, lim}, {5'h00, exp_lim(l)}, "detected limit");
        rd_reg(8'h08, stat(s));
        rd_reg(8'h07, 8'h00);
        rd_reg(8'h00, {5'h00, l});
    endtask : detect

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        @(negedge clk_i);
        chk({2'h0, conv, bsw, high_impedance_standby, minsel}, 8'h15, "reset outputs");
        chk({5'h00, lim}, 8'h00, "reset limit");
        rd_reg(8'h00, 8'h02);
        rd_reg(8'h01, 8'h1A);
        rd_reg(8'h07, 8'h00);
        rd_reg(8'h55, 8'h00);
        rd_reg(8'h08, 8'h00);
        // Slow contact near 300 ms, rail still low
        @(posedge clk_i);
        vbus <= 1'b1;
        pg <= 1'b1;
        for (n = 0; n < 10 && pg_ev !== 1'b1; n++) @(negedge clk_i);
        chk({7'h00, pg_ev}, 8'h01, "power good event");
        @(negedge clk_i);
        chk({7'h00, pg_ev}, 8'h00, "event width");
        for (n = 0; n < 10 && dp_src !== 1'b1; n++) @(negedge clk_i);
        chk({4'h0, dp_src, dm_pd, dp_vsrc, dm_sink}, 8'h0C, "contact drive");
        for (n = 0; n < 6000 && dp_vsrc !== 1'b1; n++) @(negedge clk_i);
        chk({4'h0, dp_src, dm_pd, dp_vsrc, dm_sink}, 8'h03, "primary drive");
        wait_conv(1'b1);
        chk({5'h00, lim}, 8'h00, "low rail limit");
        @(posedge clk_i);
        above <= 1'b1;
        repeat (4) @(negedge clk_i);
        chk({5'h00, lim}, {5'h00, exp_lim(3'h2)}, "rail up limit");
        rd_reg(8'h08, stat(2'h1));
        // No rerun while attached without a request
        @(posedge clk_i);
        mode <= 3'h1;
        msreg <= 1'b1;
        repeat (500) @(negedge clk_i);
        chk({5'h00, lim}, {5'h00, exp_lim(3'h2)}, "held limit");
        rd_reg(8'h08, stat(2'h1));
        wr_reg(8'h00, 8'h05);
        repeat (2) @(negedge clk_i);
        chk({5'h00, lim}, {5'h00, exp_lim(3'h5)}, "host limit");
        rd_reg(8'h00, 8'h05);
        m = 3'($random(seed));
        wr_reg(8'h01, {4'h0, m, 1'b0});
        repeat (2) @(negedge clk_i);
        chk({4'h0, bsw, minsel}, {4'h0, 1'b0, m}, "charge off");
        wr_reg(8'h01, 8'h1A);
        repeat (2) @(negedge clk_i);
        chk({7'h00, bsw}, 8'h01, "charge on");
        delay <= 13'h0032;
        for (int i = 0; i < 6; i++) begin
            detect(3'(i), src_t[i], lim_t[i], i == 2);
        end
        // Standby holds off detection until released
        wr_reg(8'h00, 8'h82);
        repeat (800) @(negedge clk_i);
        chk({5'h00, high_impedance_standby, conv, dp_src}, 8'h04, "standby");
        wr_reg(8'h00, 8'h02);
        wait_conv(1'b1);
        chk({7'h00, high_impedance_standby}, 8'h00, "standby exit");
        chk({5'h00, lim}, {5'h00, exp_lim(3'h4)}, "rerun limit");
        stop_test();
    end
endmodule : test_usb_source_detect_input_limit

// ---- dv/usb_port_model.sv ----
`timescale 1ns/10ps

// ----------------------------------------
// Far-side port: host, charging port or divider adapter
// ----------------------------------------
// Modes: 0 host, 1 charging port, 2 floating, 3..5 divider patterns 1..3
module usb_port_model (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [2:0] mode_i,
    input wire logic [12:0] delay_i,
    input wire logic dp_src_i,
    input wire logic dp_vsrc_i,
    input wire logic dm_sink_i,
    output logic dp_high_o,
    output logic dm_high_o,
    output logic [2:0] div_o
);
    logic [12:0] cnt_reg;

    // Undriven lines toggle so a stale level never passes for an answer
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_reg <= 13'h0000;
            dp_high_o <= 1'b0;
            dm_high_o <= 1'b0;
            div_o <= 3'h0;
        end else begin
            if (!dp_src_i) begin
                cnt_reg <= 13'h0000;
            end else if (cnt_reg != 13'h1FFF) begin
                cnt_reg <= cnt_reg + 13'h0001;
            end
            if (dp_src_i) begin
                dp_high_o <= (mode_i > 3'h1) || (cnt_reg < delay_i);
            end else begin
                dp_high_o <= !dp_high_o;
            end
            if (dp_vsrc_i && dm_sink_i) begin
                dm_high_o <= (mode_i == 3'h1);
            end else begin
                dm_high_o <= !dm_high_o;
            end
            div_o <= {mode_i == 3'h5, mode_i == 3'h4, mode_i == 3'h3};
        end
    end
endmodule : usb_port_model

// ---- hdl/ms_tick.sv ----
`timescale 1ns/10ps

module ms_tick #(
    parameter int CYCLES = 100000
) (
    input wire logic clk_i,
    input wire logic rst_i,
    output logic tick_o
);

    // ----------------------------------------
    // One-cycle enable every CYCLES clocks
    // ----------------------------------------
    logic [31:0] div_reg;
    logic [31:0] div_next;
    logic tick_next;

    always_comb begin
        div_next = div_reg + 32'h1;
        tick_next = 1'b0;
        if (div_reg >= 32'(CYCLES - 1)) begin
            div_next = '0;
            tick_next = 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            div_reg <= '0;
            tick_o <= 1'b0;
        end else begin
            div_reg <= div_next;
            tick_o <= tick_next;
        end
    end

endmodule : ms_tick

// ---- hdl/sync_stage.sv ----
`timescale 1ns/10ps

module sync_stage #(
    parameter int WIDTH = 1
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [WIDTH-1:0] async_i,
    output logic [WIDTH-1:0] sync_o
);

    // ----------------------------------------
    // Two flops; the first is read only by the second
    // ----------------------------------------
    logic [WIDTH-1:0] meta_reg;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            meta_reg <= '0;
            sync_o <= '0;
        end else begin
            meta_reg <= async_i;
            sync_o <= meta_reg;
        end
    end

endmodule : sync_stage

// ---- hdl/usb_detect_defines.svh ----
`ifndef USB_DETECT_DEFINES_SVH
`define USB_DETECT_DEFINES_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define ADDR_INPUT_CTRL 8'h00
`define ADDR_CHARGE_CTRL 8'h01
`define ADDR_MISC_CTRL 8'h07
`define ADDR_STATUS 8'h08

// ----------------------------------------
// Field positions
// ----------------------------------------
`define STANDBY_BIT 7
`define LIMIT_MSB 2
`define LIMIT_LSB 0
`define CHG_MSB 5
`define CHG_LSB 4
`define MINSYS_MSB 3
`define MINSYS_LSB 1
`define FORCE_BIT 7
`define SRC_MSB 7
`define SRC_LSB 6
`define PG_BIT 2
`define MINSYS_STAT_BIT 0

// ----------------------------------------
// Reset values and codes
// ----------------------------------------
`define LIMIT_RESET 3'h2
`define MINSYS_RESET 3'h5
`define CHG_RESET 2'h1
`define CHG_ENABLED 2'h1
`define LIM_100MA 3'h0
`define LIM_500MA 3'h2
`define LIM_1A 3'h4
`define LIM_2A 3'h6
`define LIM_3A 3'h7
`define SRC_UNKNOWN 2'h0
`define SRC_HOST 2'h1
`define SRC_ADAPTER 2'h2

// ----------------------------------------
// Timing
// ----------------------------------------
`define CLK_PERIOD_NS 10
`define MS_TIME_NS 1000000
`define DCD_ON_TIME_MS 10'h028
`define DCD_TIMEOUT_MS 10'h1F4
`define PRIMARY_TIME_MS 10'h028

`endif

// ---- hdl/usb_detect_pkg.sv ----
package usb_detect_pkg;

    // ----------------------------------------
    // Types
    // ----------------------------------------
    typedef enum logic [4:0] {
        ST_IDLE = 5'h01,
        ST_CONTACT = 5'h02,
        ST_PRIMARY = 5'h04,
        ST_NONSTD = 5'h08,
        ST_DONE = 5'h10
    } detect_state_t;

    typedef logic [2:0] limit_code_t;
    typedef logic [9:0] ms_count_t;

endpackage : usb_detect_pkg

// ---- hdl/usb_source_detect.sv ----
// Decided for this implementation: the register offsets and strobed register access.
`timescale 1ns/10ps
`include "usb_detect_defines.svh"

module usb_source_detect #(
    parameter int TICK_CYCLES = `MS_TIME_NS / `CLK_PERIOD_NS
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [7:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [7:0] rdata_o,
    input wire logic vbus_present_i,
    input wire logic power_good_i,
    input wire logic dp_high_i,
    input wire logic dm_high_i,
    input wire logic divider1_i,
    input wire logic divider2_i,
    input wire logic divider3_i,
    input wire logic sys_above_min_i,
    input wire logic min_sys_regulating_i,
    input wire logic [2:0] external_limit_pin_i,
    input wire logic watchdog_timeout_i,
    output logic dp_current_source_o,
    output logic dm_pulldown_o,
    output logic dp_voltage_source_o,
    output logic dm_current_sink_o,
    output logic [2:0] input_limit_o,
    output logic converter_enable_o,
    output logic battery_switch_o,
    output logic high_impedance_standby_o,
    output logic [2:0] min_sys_select_o,
    output logic power_good_event_o
);

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic elapsed(input usb_detect_pkg::ms_count_t cnt,
                                     input usb_detect_pkg::ms_count_t lim);
        elapsed = (cnt >= lim);
    endfunction : elapsed

    function automatic usb_detect_pkg::limit_code_t lower(input usb_detect_pkg::limit_code_t a,
                                                          input usb_detect_pkg::limit_code_t b);
        lower = (a < b) ? a : b;
    endfunction : lower

    // ----------------------------------------
    // Input synchronisers and ms tick
    // ----------------------------------------
    logic [11:0] sync_in;
    logic [11:0] sync_out;
    logic vbus_s, pg_s, dp_s, dm_s, div1_s, div2_s, div3_s, sys_ok_s, minreg_s;
    logic [2:0] ext_s;
    logic tick;

    assign sync_in = {vbus_present_i, power_good_i, dp_high_i, dm_high_i, divider1_i, divider2_i,
                      divider3_i, sys_above_min_i, min_sys_regulating_i, external_limit_pin_i};
    assign {vbus_s, pg_s, dp_s, dm_s, div1_s, div2_s, div3_s, sys_ok_s, minreg_s, ext_s} = sync_out;

    sync_stage #(.WIDTH(12)) u_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .async_i(sync_in),
        .sync_o(sync_out)
    );

    ms_tick #(.CYCLES(TICK_CYCLES)) u_tick (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .tick_o(tick)
    );

    // ----------------------------------------
    // State
    // ----------------------------------------
    usb_detect_pkg::detect_state_t state_reg, state_next;
    usb_detect_pkg::ms_count_t ms_reg, ms_next;
    usb_detect_pkg::limit_code_t limit_reg, limit_next, eff_next;
    logic forced_reg, forced_next;
    logic standby_reg, standby_next;
    logic force_reg, force_next;
    logic [1:0] chg_reg, chg_next;
    logic [2:0] minsys_reg, minsys_next;
    logic [1:0] src_reg, src_next;
    logic pg_prev_reg;
    logic [7:0] rdata_next;
    logic attached, finish, conv_next;

    assign attached = vbus_s && pg_s && !standby_reg;

    // ----------------------------------------
    // Next-state logic
    // ----------------------------------------
    always_comb begin
        state_next = state_reg;
        ms_next = ms_reg;
        forced_next = forced_reg;
        limit_next = limit_reg;
        standby_next = standby_reg;
        force_next = force_reg;
        chg_next = chg_reg;
        minsys_next = minsys_reg;
        src_next = src_reg;
        finish = 1'b0;
        if (tick) begin
            ms_next = ms_reg + 10'h001;
        end
        unique case (state_reg)
            usb_detect_pkg::ST_IDLE: begin
                forced_next = 1'b0;
                if (attached) begin
                    state_next = usb_detect_pkg::ST_CONTACT;
                    ms_next = '0;
                end
            end
            usb_detect_pkg::ST_CONTACT: begin
                if (!attached) begin
                    state_next = usb_detect_pkg::ST_IDLE;
                end else if (elapsed(ms_reg, `DCD_ON_TIME_MS) && !dp_s) begin
                    state_next = usb_detect_pkg::ST_PRIMARY;
                    ms_next = '0;
                end else if (elapsed(ms_reg, `DCD_TIMEOUT_MS)) begin
                    state_next = usb_detect_pkg::ST_NONSTD;
                end
            end
            usb_detect_pkg::ST_PRIMARY: begin
                if (!attached) begin
                    state_next = usb_detect_pkg::ST_IDLE;
                end else if (elapsed(ms_reg, `PRIMARY_TIME_MS)) begin
                    finish = 1'b1;
                    src_next = dm_s ? `SRC_ADAPTER : `SRC_HOST;
                    limit_next = dm_s ? `LIM_3A : `LIM_500MA;
                end
            end
            usb_detect_pkg::ST_NONSTD: begin
                if (!attached) begin
                    state_next = usb_detect_pkg::ST_IDLE;
                end else begin
                    finish = 1'b1;
                    if (div1_s || div2_s) begin
                        src_next = `SRC_ADAPTER;
                        limit_next = `LIM_2A;
                    end else if (div3_s) begin
                        src_next = `SRC_ADAPTER;
                        limit_next = `LIM_1A;
                    end else begin
                        src_next = `SRC_UNKNOWN;
                        limit_next = `LIM_500MA;
                    end
                end
            end
            usb_detect_pkg::ST_DONE: begin
                if (!attached) begin
                    state_next = usb_detect_pkg::ST_IDLE;
                end else if (force_reg || watchdog_timeout_i) begin
                    state_next = usb_detect_pkg::ST_CONTACT;
                    forced_next = 1'b1;
                    ms_next = '0;
                end
            end
        endcase
        if (finish) begin
            state_next = usb_detect_pkg::ST_DONE;
            forced_next = 1'b0;
            force_next = 1'b0;
        end
        // Software writes land after hardware updates, so a set of the force bit wins
        if (wr_i) begin
            unique case (addr_i)
                `ADDR_INPUT_CTRL: begin
                    standby_next = wdata_i[`STANDBY_BIT];
                    limit_next = wdata_i[`LIMIT_MSB:`LIMIT_LSB];
                end
                `ADDR_CHARGE_CTRL: begin
                    chg_next = wdata_i[`CHG_MSB:`CHG_LSB];
                    minsys_next = wdata_i[`MINSYS_MSB:`MINSYS_LSB];
                end
                `ADDR_MISC_CTRL: begin
                    if (wdata_i[`FORCE_BIT]) begin
                        force_next = 1'b1;
                    end
                end
                default: begin
                end
            endcase
        end
    end

    // ----------------------------------------
    // Outputs and read data
    // ----------------------------------------
    always_comb begin
        if (forced_next || !sys_ok_s) begin
            eff_next = `LIM_100MA;
        end else begin
            eff_next = lower(limit_next, ext_s);
        end
        conv_next = (state_next == usb_detect_pkg::ST_DONE) && !forced_next;
        rdata_next = 8'h00;
        if (rd_i) begin
            unique case (addr_i)
                `ADDR_INPUT_CTRL: begin
                    rdata_next[`STANDBY_BIT] = standby_reg;
                    rdata_next[`LIMIT_MSB:`LIMIT_LSB] = limit_reg;
                end
                `ADDR_CHARGE_CTRL: begin
                    rdata_next[`CHG_MSB:`CHG_LSB] = chg_reg;
                    rdata_next[`MINSYS_MSB:`MINSYS_LSB] = minsys_reg;
                end
                `ADDR_MISC_CTRL: begin
                    rdata_next[`FORCE_BIT] = force_reg;
                end
                `ADDR_STATUS: begin
                    rdata_next[`SRC_MSB:`SRC_LSB] = src_reg;
                    rdata_next[`PG_BIT] = pg_s;
                    rdata_next[`MINSYS_STAT_BIT] = minreg_s;
                end
                default: begin
                end
            endcase
        end
    end

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_reg <= usb_detect_pkg::ST_IDLE;
            ms_reg <= '0;
            forced_reg <= 1'b0;
            limit_reg <= `LIMIT_RESET;
            standby_reg <= 1'b0;
            force_reg <= 1'b0;
            chg_reg <= `CHG_RESET;
            minsys_reg <= `MINSYS_RESET;
            src_reg <= `SRC_UNKNOWN;
            pg_prev_reg <= 1'b0;
            rdata_o <= 8'h00;
            dp_current_source_o <= 1'b0;
            dm_pulldown_o <= 1'b0;
            dp_voltage_source_o <= 1'b0;
            dm_current_sink_o <= 1'b0;
            input_limit_o <= `LIM_100MA;
            converter_enable_o <= 1'b0;
            battery_switch_o <= 1'b1;
            high_impedance_standby_o <= 1'b0;
            min_sys_select_o <= `MINSYS_RESET;
            power_good_event_o <= 1'b0;
        end else begin
            state_reg <= state_next;
            ms_reg <= ms_next;
            forced_reg <= forced_next;
            limit_reg <= limit_next;
            standby_reg <= standby_next;
            force_reg <= force_next;
            chg_reg <= chg_next;
            minsys_reg <= minsys_next;
            src_reg <= src_next;
            pg_prev_reg <= pg_s;
            rdata_o <= rdata_next;
            dp_current_source_o <= (state_next == usb_detect_pkg::ST_CONTACT);
            dm_pulldown_o <= (state_next == usb_detect_pkg::ST_CONTACT);
            dp_voltage_source_o <= (state_next == usb_detect_pkg::ST_PRIMARY);
            dm_current_sink_o <= (state_next == usb_detect_pkg::ST_PRIMARY);
            input_limit_o <= eff_next;
            converter_enable_o <= conv_next;
            battery_switch_o <= !(conv_next && (chg_next != `CHG_ENABLED));
            high_impedance_standby_o <= standby_next;
            min_sys_select_o <= minsys_next;
            power_good_event_o <= pg_s && !pg_prev_reg;
        end
    end

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    sequence primary_end_s;
        (state_reg == usb_detect_pkg::ST_PRIMARY) && attached && elapsed(ms_reg, `PRIMARY_TIME_MS) && !wr_i;
    endsequence

    sequence contact_timeout_s;
        (state_reg == usb_detect_pkg::ST_CONTACT) && attached && dp_s
            && elapsed(ms_reg, `DCD_TIMEOUT_MS);
    endsequence

    host_result_a: assert property (@(posedge clk_i) disable iff (rst_i)
        primary_end_s ##0 !dm_s |=> src_reg == `SRC_HOST && limit_reg == `LIM_500MA)
        else $error("host port result wrong");

    port_result_a: assert property (@(posedge clk_i) disable iff (rst_i)
        primary_end_s ##0 dm_s |=> src_reg == `SRC_ADAPTER && limit_reg == `LIM_3A)
        else $error("charging port result wrong");

    timeout_path_a: assert property (@(posedge clk_i) disable iff (rst_i)
        contact_timeout_s |=> state_reg == usb_detect_pkg::ST_NONSTD ##1 state_reg != usb_detect_pkg::ST_PRIMARY)
        else $error("contact timeout path wrong");

    divider_limit_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (state_reg == usb_detect_pkg::ST_NONSTD) && attached && !wr_i && !div1_s && !div2_s && div3_s
            |=> limit_reg == `LIM_1A && src_reg == `SRC_ADAPTER)
        else $error("divider three limit wrong");

    unknown_result_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (state_reg == usb_detect_pkg::ST_NONSTD) && attached && !wr_i && !div1_s && !div2_s && !div3_s
            |=> limit_reg == `LIM_500MA && src_reg == `SRC_UNKNOWN)
        else $error("unknown source result wrong");

    forced_limit_a: assert property (@(posedge clk_i) disable iff (rst_i)
        forced_reg |-> input_limit_o == `LIM_100MA && !converter_enable_o)
        else $error("forced detection limit not held");

    force_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
        primary_end_s ##0 forced_reg |=> !force_reg && !forced_reg && state_reg == usb_detect_pkg::ST_DONE)
        else $error("force bit not cleared at end");

    soft_start_a: assert property (@(posedge clk_i) disable iff (rst_i)
        !sys_ok_s |=> input_limit_o == `LIM_100MA)
        else $error("soft start limit not forced");

    standby_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
        standby_reg && !(wr_i && addr_i == `ADDR_INPUT_CTRL) |=> standby_reg ##1 state_reg == usb_detect_pkg::ST_IDLE)
        else $error("standby not held");

    contact_drive_a: assert property (@(posedge clk_i) disable iff (rst_i)
        $rose(state_reg == usb_detect_pkg::ST_CONTACT) |-> dp_current_source_o && dm_pulldown_o
            && !dp_voltage_source_o)
        else $error("contact detect drive wrong");

    contact_min_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (state_reg == usb_detect_pkg::ST_CONTACT) && !elapsed(ms_reg, `DCD_ON_TIME_MS)
            |=> state_reg != usb_detect_pkg::ST_PRIMARY)
        else $error("contact left before 40 ms");

endmodule : usb_source_detect
